// ==== front_panel_pkg.sv ====
package front_panel_pkg;
    // register byte offsets
    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] AGAIN_OFS  = 12'h004;
    localparam logic [11:0] VGAIN_OFS  = 12'h008;
    localparam logic [11:0] STATUS_OFS = 12'h00c;
    localparam logic [11:0] EDIT_OFS   = 12'h010;
    localparam logic [11:0] PARAM_OFS  = 12'h040;
    localparam logic [11:0] PARAM_END  = 12'h07c;
    // control field positions
    localparam int CTRL_AMODE = 0;
    localparam int CTRL_FMT   = 2;
    localparam int CTRL_ASP   = 5;
    localparam int CTRL_BARS  = 7;
    localparam int CTRL_GRAT  = 8;
    localparam int CTRL_W     = 9;
    // audio i/o modes
    localparam logic [1:0] AM_MUX8  = 2'h0;
    localparam logic [1:0] AM_MUX4  = 2'h1;
    localparam logic [1:0] AM_DEMUX = 2'h2;
    // output formats
    localparam logic [2:0] FMT_1080I  = 3'h0;
    localparam logic [2:0] FMT_720P   = 3'h1;
    localparam logic [2:0] FMT_1080P  = 3'h2;
    localparam logic [2:0] FMT_1080SF = 3'h3;
    localparam logic [2:0] FMT_SD     = 3'h4;
    // aspect modes
    localparam logic [1:0] ASP_ANAM   = 2'h0;
    localparam logic [1:0] ASP_BOX    = 2'h1;
    localparam logic [1:0] ASP_CROP   = 2'h2;
    localparam logic [1:0] ASP_MANUAL = 2'h3;
    // reference status codes
    localparam logic [2:0] REF_MISMATCH = 3'h0;
    localparam logic [2:0] REF_UNLOCKED = 3'h1;
    localparam logic [2:0] REF_TLS_LOCK = 3'h2;
    localparam logic [2:0] REF_NONE     = 3'h3;
    localparam logic [2:0] REF_525_LOCK = 3'h4;
    localparam logic [2:0] REF_625_LOCK = 3'h5;
    // lamp colours
    localparam logic [1:0] LAMP_OFF    = 2'h0;
    localparam logic [1:0] LAMP_GREEN  = 2'h1;
    localparam logic [1:0] LAMP_RED    = 2'h2;
    localparam logic [1:0] LAMP_YELLOW = 2'h3;
    // gain and reset values
    localparam logic [7:0]  GAIN_UNITY  = 8'h80;
    localparam logic [7:0]  PARAM_RESET = 8'h00;
    localparam logic [7:0]  PARAM_MAX   = 8'hff;
    localparam logic [8:0]  CTRL_RESET  = 9'h000;
    localparam int NUM_PAIRS    = 4;
    localparam int NUM_SECTIONS = 4;
    localparam int NUM_SEL      = 4;
    localparam int NUM_PARAMS   = NUM_SECTIONS * NUM_SEL;
    // synchroniser bit positions
    localparam int SY_MODE  = 0;
    localparam int SY_RIGHT = 1;
    localparam int SY_LEFT  = 2;
    localparam int SY_EMBED = 3;
    localparam int SY_SDI   = 4;
    localparam int SY_HD    = 5;
    localparam int SY_REF   = 6;
    localparam int SY_LASER = 7;
    localparam int SY_RSTAT = 8;
    localparam int SY_OVER  = 11;
    localparam int SY_HOT   = 15;
    localparam int SYNC_W   = 19;
    // timing
    localparam longint CLK_HZ        = 10_000_000;
    localparam longint COMMIT_TIME_S = 15;
    localparam longint BLINK_TIME_MS = 250;
    localparam int COMMIT_CYC = int'(COMMIT_TIME_S * CLK_HZ);
    localparam int BLINK_CYC  = int'((BLINK_TIME_MS * CLK_HZ) / 1000);
endpackage

// ==== front_panel_status_control.sv ====
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
module front_panel_status_control #(
    parameter int COMMIT_CYCLES = front_panel_pkg::COMMIT_CYC,
    parameter int BLINK_CYCLES  = front_panel_pkg::BLINK_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        btn_mode,
    input  wire logic        btn_right,
    input  wire logic        btn_left,
    input  wire logic        embed_detect,
    input  wire logic        input_is_sdi,
    input  wire logic        input_is_hd,
    input  wire logic        ref_valid,
    input  wire logic        laser_detect,
    input  wire logic [2:0]  ref_status,
    input  wire logic [3:0]  level_over,
    input  wire logic [3:0]  level_hot,
    output logic [3:0]       audio_port_out,
    output logic [7:0]       port_chan_count,
    output logic             cpst_out_en,
    output logic [1:0]       embed_lamp,
    output logic [7:0]       gain_lamp,
    output logic [7:0]       level_meter_lamp,
    output logic [1:0]       mon_vol_lamp,
    output logic [2:0]       audio_mode_lamp,
    output logic             in_hd_lamp,
    output logic             in_sd_lamp,
    output logic             ref_lamp,
    output logic [4:0]       fmt_lamp,
    output logic [1:0]       laser_lamp,
    output logic [3:0]       aspect_lamp,
    output logic [1:0]       bars_lamp,
    output logic [1:0]       grat_lamp,
    output logic [1:0]       vgain_lamp,
    output logic             param_lamp_on,
    output logic [3:0]       param_lamp_idx,
    output logic             nv_we,
    output logic [3:0]       nv_addr,
    output logic [7:0]       nv_data
);
    import front_panel_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0]          sync1;
        logic [SYNC_W-1:0]          sync2;
        logic [2:0]                 btn_prev;
        logic [CTRL_W-1:0]          ctrl;
        logic [NUM_PAIRS-1:0][7:0]  pair_gain;
        logic [7:0]                 vid_gain;
        logic [7:0]                 mon_vol;
        logic                       edit_on;
        logic                       adjust;
        logic [1:0]                 section;
        logic [1:0]                 sel;
        logic [NUM_PARAMS-1:0][7:0] params;
        logic                       pending;
        logic [3:0]                 pend_idx;
        logic [31:0]                timer;
        logic [31:0]                blink_cnt;
        logic                       blink_ph;
        logic                       nv_we;
        logic [3:0]                 nv_addr;
        logic [7:0]                 nv_data;
        logic [3:0]                 port_out;
        logic [7:0]                 chan_cnt;
        logic                       cpst_en;
        logic [1:0]                 embed_lamp;
        logic [7:0]                 gain_lamp;
        logic [7:0]                 level_lamp;
        logic [1:0]                 mon_lamp;
        logic [2:0]                 amode_lamp;
        logic                       hd_lamp;
        logic                       sd_lamp;
        logic                       ref_lamp;
        logic [4:0]                 fmt_lamp;
        logic [1:0]                 laser_lamp;
        logic [3:0]                 asp_lamp;
        logic [1:0]                 bars_lamp;
        logic [1:0]                 grat_lamp;
        logic [1:0]                 vgain_lamp;
        logic                       plamp_on;
        logic [3:0]                 plamp_idx;
        logic                       pready;
        logic                       pslverr;
        logic [31:0]                prdata;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic [2:0] btn_rise;
    logic       both_arrows;
    logic       edit_evt;
    logic [3:0] cur_idx;
    logic [1:0] amode;
    logic [2:0] fmt;
    logic [1:0] asp;
    logic       wr_take;

    // decoded views of the current state
    assign btn_rise    = st_r.sync2[SY_LEFT:SY_MODE] & ~st_r.btn_prev;
    assign both_arrows = btn_rise[SY_RIGHT] & btn_rise[SY_LEFT];
    assign edit_evt    = st_r.edit_on & st_r.adjust & ~both_arrows
                         & (btn_rise[SY_RIGHT] | btn_rise[SY_LEFT]) & ~btn_rise[SY_MODE];
    assign cur_idx     = {st_r.section, st_r.sel};
    assign amode       = st_r.ctrl[CTRL_AMODE +: 2];
    assign fmt         = st_r.ctrl[CTRL_FMT +: 3];
    assign asp         = st_r.ctrl[CTRL_ASP +: 2];
    assign wr_take     = psel & penable & st_r.pready & pwrite;

    // next-state logic
    always_comb begin
        st_nxt = st_r;
        // two-flop synchroniser for all button and status pins
        st_nxt.sync1 = {level_hot, level_over, ref_status, laser_detect, ref_valid,
                        input_is_hd, input_is_sdi, embed_detect, btn_left, btn_right,
                        btn_mode};
        st_nxt.sync2    = st_r.sync1;
        st_nxt.btn_prev = st_r.sync2[SY_LEFT:SY_MODE];

        // apb slave, zero wait states, answer prepared in setup cycle
        st_nxt.pready  = psel & ~penable;
        st_nxt.pslverr = 1'b0;
        st_nxt.prdata  = 32'h0;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                CTRL_OFS:   st_nxt.prdata = {23'h0, st_r.ctrl};
                AGAIN_OFS:  st_nxt.prdata = st_r.pair_gain;
                VGAIN_OFS:  st_nxt.prdata = {16'h0, st_r.mon_vol, st_r.vid_gain};
                // reference state passed through as one of six codes
                STATUS_OFS: st_nxt.prdata = {16'h0, st_r.sync2[SY_OVER +: 8],
                                             st_r.sync2[SY_RSTAT +: 3],
                                             st_r.sync2[SY_LASER:SY_EMBED]};
                EDIT_OFS:   st_nxt.prdata = {20'h0, st_r.pend_idx, st_r.pending,
                                             st_r.adjust, st_r.sel, st_r.section,
                                             1'b0, st_r.edit_on};
                default: begin
                    if (paddr >= PARAM_OFS && paddr <= PARAM_END && paddr[1:0] == 2'h0) begin
                        st_nxt.prdata = {24'h0, st_r.params[paddr[5:2]]};
                    end else begin
                        st_nxt.pslverr = 1'b1;
                    end
                end
            endcase
        end else if (psel && !penable) begin
            st_nxt.pslverr = !(paddr == CTRL_OFS || paddr == AGAIN_OFS
                               || paddr == VGAIN_OFS || paddr == STATUS_OFS
                               || paddr == EDIT_OFS
                               || (paddr >= PARAM_OFS && paddr <= PARAM_END
                                   && paddr[1:0] == 2'h0));
        end
        // writes land at the access edge; read-only words ignore writes
        if (wr_take) begin
            unique case (paddr)
                CTRL_OFS:  st_nxt.ctrl = pwdata[CTRL_W-1:0];
                AGAIN_OFS: st_nxt.pair_gain = pwdata;
                VGAIN_OFS: begin
                    st_nxt.vid_gain = pwdata[7:0];
                    st_nxt.mon_vol  = pwdata[15:8];
                end
                default: ;
            endcase
        end

        // front-panel button handling
        if (btn_rise[SY_MODE]) begin
            st_nxt.edit_on = 1'b1;
            st_nxt.section = st_r.edit_on ? st_r.section + 2'h1 : 2'h0;
            st_nxt.sel     = 2'h0;
            st_nxt.adjust  = 1'b0;
        end else if (st_r.edit_on && both_arrows) begin
            st_nxt.adjust = ~st_r.adjust; // both arrows swap select/adjust
        end else if (st_r.edit_on && !st_r.adjust) begin
            if (btn_rise[SY_RIGHT]) begin
                st_nxt.sel = st_r.sel + 2'h1;
            end else if (btn_rise[SY_LEFT]) begin
                st_nxt.sel = st_r.sel - 2'h1;
            end
        end else if (edit_evt) begin
            if (btn_rise[SY_RIGHT] && st_r.params[cur_idx] != PARAM_MAX) begin
                st_nxt.params[cur_idx] = st_r.params[cur_idx] + 8'h01;
            end else if (btn_rise[SY_LEFT] && st_r.params[cur_idx] != 8'h00) begin
                st_nxt.params[cur_idx] = st_r.params[cur_idx] - 8'h01;
            end
        end

        // commit timer: storage written when the interval expires or another parameter takes over
        st_nxt.nv_we = 1'b0;
        if (edit_evt) begin
            if (st_r.pending && st_r.pend_idx != cur_idx) begin
                // another parameter took over: old one commits now
                st_nxt.nv_we   = 1'b1;
                st_nxt.nv_addr = st_r.pend_idx;
                st_nxt.nv_data = st_r.params[st_r.pend_idx];
            end
            st_nxt.pending  = 1'b1;
            st_nxt.pend_idx = cur_idx;
            st_nxt.timer    = 32'(COMMIT_CYCLES - 1);
        end else if (st_r.pending) begin
            if (st_r.timer == 32'h0) begin
                st_nxt.pending = 1'b0;
                st_nxt.nv_we   = 1'b1;
                st_nxt.nv_addr = st_r.pend_idx;
                st_nxt.nv_data = st_r.params[st_r.pend_idx];
            end else begin
                st_nxt.timer = st_r.timer - 32'h1;
            end
        end

        // blink clock for the pending parameter lamp
        if (st_r.blink_cnt == 32'h0) begin
            st_nxt.blink_cnt = 32'(BLINK_CYCLES - 1);
            st_nxt.blink_ph  = ~st_r.blink_ph;
        end else begin
            st_nxt.blink_cnt = st_r.blink_cnt - 32'h1;
        end
        st_nxt.plamp_on  = st_r.pending ? st_r.blink_ph : st_r.edit_on;
        st_nxt.plamp_idx = st_r.pending ? st_r.pend_idx : cur_idx;

        // audio port directions, one channel pair of two channels each
        unique case (amode)
            AM_DEMUX: st_nxt.port_out = 4'hf;
            AM_MUX4:  st_nxt.port_out = 4'hc;
            default:  st_nxt.port_out = 4'h0;
        endcase
        st_nxt.chan_cnt   = {NUM_PAIRS{2'h2}};
        st_nxt.amode_lamp = 3'(3'h1 << amode);

        // video lamps and composite enable
        st_nxt.cpst_en    = (fmt == FMT_SD);
        st_nxt.embed_lamp = (st_r.sync2[SY_EMBED] && st_r.sync2[SY_SDI])
                            ? LAMP_GREEN : LAMP_OFF;
        st_nxt.hd_lamp    = st_r.sync2[SY_HD];
        st_nxt.sd_lamp    = ~st_r.sync2[SY_HD];
        st_nxt.ref_lamp   = st_r.sync2[SY_REF];
        st_nxt.fmt_lamp   = 5'(5'h01 << fmt);
        st_nxt.laser_lamp = st_r.sync2[SY_LASER] ? LAMP_GREEN : LAMP_OFF;
        st_nxt.asp_lamp   = 4'(4'h1 << asp);
        st_nxt.bars_lamp  = st_r.ctrl[CTRL_BARS] ? LAMP_GREEN : LAMP_OFF;
        st_nxt.grat_lamp  = st_r.ctrl[CTRL_GRAT] ? LAMP_GREEN : LAMP_OFF;
        st_nxt.vgain_lamp = (st_r.vid_gain == GAIN_UNITY) ? LAMP_GREEN : LAMP_RED;
        st_nxt.mon_lamp   = (st_r.mon_vol == GAIN_UNITY) ? LAMP_GREEN : LAMP_RED;

        // per-pair gain and level lamps
        for (int p = 0; p < NUM_PAIRS; p++) begin
            st_nxt.gain_lamp[2*p +: 2] = (st_r.pair_gain[p] == GAIN_UNITY)
                                         ? LAMP_GREEN : LAMP_RED;
            if (st_r.sync2[SY_OVER + p]) begin
                st_nxt.level_lamp[2*p +: 2] = LAMP_RED;
            end else if (st_r.sync2[SY_HOT + p]) begin
                st_nxt.level_lamp[2*p +: 2] = LAMP_YELLOW;
            end else begin
                st_nxt.level_lamp[2*p +: 2] = st_nxt.gain_lamp[2*p +: 2];
            end
        end
    end

    // state register; reset drops any uncommitted edit
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r           <= '0;
            st_r.ctrl      <= CTRL_RESET;
            st_r.pair_gain <= {NUM_PAIRS{GAIN_UNITY}};
            st_r.vid_gain  <= GAIN_UNITY;
            st_r.mon_vol   <= GAIN_UNITY;
            st_r.params    <= {NUM_PARAMS{PARAM_RESET}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign prdata           = st_r.prdata;
    assign pready           = st_r.pready;
    assign pslverr          = st_r.pslverr;
    assign audio_port_out   = st_r.port_out;
    assign port_chan_count  = st_r.chan_cnt;
    assign cpst_out_en      = st_r.cpst_en;
    assign embed_lamp       = st_r.embed_lamp;
    assign gain_lamp        = st_r.gain_lamp;
    assign level_meter_lamp = st_r.level_lamp;
    assign mon_vol_lamp     = st_r.mon_lamp;
    assign audio_mode_lamp  = st_r.amode_lamp;
    assign in_hd_lamp       = st_r.hd_lamp;
    assign in_sd_lamp       = st_r.sd_lamp;
    assign ref_lamp         = st_r.ref_lamp;
    assign fmt_lamp         = st_r.fmt_lamp;
    assign laser_lamp       = st_r.laser_lamp;
    assign aspect_lamp      = st_r.asp_lamp;
    assign bars_lamp        = st_r.bars_lamp;
    assign grat_lamp        = st_r.grat_lamp;
    assign vgain_lamp       = st_r.vgain_lamp;
    assign param_lamp_on    = st_r.plamp_on;
    assign param_lamp_idx   = st_r.plamp_idx;
    assign nv_we            = st_r.nv_we;
    assign nv_addr          = st_r.nv_addr;
    assign nv_data          = st_r.nv_data;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_edit;
        edit_evt;
    endsequence
    sequence s_armed;
        (st_r.pending && st_r.timer == 32'(COMMIT_CYCLES - 1)) ##1 st_r.pending;
    endsequence

    a_mux8_all_in: assert property (amode == AM_MUX8 |=> audio_port_out == 4'h0)
        else $error("mux8 mode left a port as output");
    a_demux_all_out: assert property (amode == AM_DEMUX |=> audio_port_out == 4'hf)
        else $error("demux mode left a port as input");
    a_mux4_split: assert property (amode == AM_MUX4 |=> $countones(audio_port_out) == 2)
        else $error("mux4 mode not split two and two");
    a_cpst_sd_only: assert property (cpst_out_en |-> $past(fmt) == FMT_SD)
        else $error("composite enabled for non SD output");
    a_embed_sdi: assert property (embed_lamp == LAMP_GREEN |-> $past(st_r.sync2[SY_SDI]))
        else $error("embed lamp lit for non SDI input");
    a_pair_gain: assert property (st_r.pair_gain[0] != GAIN_UNITY
                                  |=> gain_lamp[1:0] == LAMP_RED)
        else $error("pair gain lamp not red off unity");
    a_level_over: assert property (st_r.sync2[SY_OVER]
                                   |=> level_meter_lamp[1:0] == LAMP_RED)
        else $error("level lamp not red over headroom");
    a_vgain_lamp: assert property (st_r.vid_gain == GAIN_UNITY
                                   |=> vgain_lamp == LAMP_GREEN)
        else $error("video gain lamp not green at unity");
    a_restart_timer: assert property (s_edit |=> s_armed)
        else $error("edit did not restart commit interval");
    a_commit_write: assert property (st_r.pending && st_r.timer == 32'h0 && !edit_evt
                                     |=> nv_we && nv_addr == $past(st_r.pend_idx)
                                         ##1 !nv_we)
        else $error("timeout did not commit the value");
    a_mode_enables: assert property (btn_rise[SY_MODE] |=> st_r.edit_on && !st_r.adjust)
        else $error("mode press did not enable editing");
    // lamps follow synced pins and registers one cycle later
    a_mon_vol_red: assert property (st_r.mon_vol != GAIN_UNITY
                                    |=> mon_vol_lamp == LAMP_RED)
        else $error("monitor volume lamp not red off unity");
    a_vgain_red: assert property (st_r.vid_gain != GAIN_UNITY
                                  |=> vgain_lamp == LAMP_RED)
        else $error("video gain lamp not red off unity");
    a_level_hot: assert property (!st_r.sync2[SY_OVER] && st_r.sync2[SY_HOT]
                                  |=> level_meter_lamp[1:0] == LAMP_YELLOW)
        else $error("level lamp not yellow above zero meter");
    a_hd_lamp: assert property (st_r.sync2[SY_HD] |=> in_hd_lamp && !in_sd_lamp)
        else $error("input lamps wrong for HD input");
    a_ref_lamp: assert property (st_r.sync2[SY_REF] |=> ref_lamp)
        else $error("reference lamp dark with valid reference");
    a_fmt_onehot: assert property (fmt <= FMT_SD |=> $onehot(fmt_lamp))
        else $error("format lamps not one hot");
    a_laser_lamp: assert property (st_r.sync2[SY_LASER] |=> laser_lamp == LAMP_GREEN)
        else $error("laser lamp dark with optical signal");
    a_manual_lamp: assert property (asp == ASP_MANUAL |=> aspect_lamp == 4'h8)
        else $error("manual aspect lamp not lit");
    a_bars_lamp: assert property (st_r.ctrl[CTRL_BARS] |=> bars_lamp == LAMP_GREEN)
        else $error("bars lamp dark with bars selected");
    a_grat_lamp: assert property (st_r.ctrl[CTRL_GRAT] |=> grat_lamp == LAMP_GREEN)
        else $error("graticule lamp dark with overlay on");
    a_sel_step: assert property (st_r.edit_on && !st_r.adjust && btn_rise == 3'b010
                                 |=> st_r.sel == $past(st_r.sel) + 2'h1)
        else $error("right arrow did not step the selection");
    a_blink_lamp: assert property (st_r.pending
                                   |=> param_lamp_on == $past(st_r.blink_ph))
        else $error("pending parameter lamp not blinking");
endmodule

// ==== front_panel_model.sv ====
`timescale 1ns/10ps
module front_panel_model (
    input  wire logic sys_clk,
    output logic      btn_mode,
    output logic      btn_right,
    output logic      btn_left
);
    // buttons idle released
    initial begin
        btn_mode = 1'b0;
        btn_right = 1'b0;
        btn_left = 1'b0;
    end
    // hold a press past the two-flop sync, then release as long
    task automatic press(input logic [2:0] b);
        @(posedge sys_clk);
        btn_mode <= b[2];
        btn_right <= b[1];
        btn_left <= b[0];
        repeat (4) @(posedge sys_clk);
        btn_mode <= 1'b0;
        btn_right <= 1'b0;
        btn_left <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
endmodule

// ==== front_panel_status_control_tb.sv ====
`timescale 1ns/10ps
module front_panel_status_control_tb;
    import front_panel_pkg::*;
    localparam int CMT = 20;
    logic sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [11:0] paddr = 12'h000, nv_last;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [4:0] pin = 5'h00, pv, fmt_lamp;
    logic [3:0] lo = 4'h0, lh = 4'h0, port_out, aspect_lamp, nv_addr;
    logic [2:0] rs = 3'h0, amode_lamp;
    logic [7:0] chan_cnt, gain_lamp, level_meter_lamp, nv_data;
    logic [1:0] embed_lamp, mon_vol_lamp, laser_lamp, bars_lamp, grat_lamp, vgain_lamp;
    logic pready, pslverr, cpst_out_en, in_hd_lamp, in_sd_lamp, ref_lamp, nv_we, bm, br, bl;
    logic plamp_on, lp;
    logic [3:0] plamp_idx;
    int num_errors = 0, n_checks = 0, cyc = 0, nv_cnt = 0;
    front_panel_model fp (.sys_clk(sys_clk), .btn_mode(bm), .btn_right(br), .btn_left(bl));
    front_panel_status_control #(.COMMIT_CYCLES(CMT), .BLINK_CYCLES(4)) u_dut (
        .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .btn_mode(bm), .btn_right(br), .btn_left(bl), .embed_detect(pin[0]),
        .input_is_sdi(pin[1]), .input_is_hd(pin[2]), .ref_valid(pin[3]),
        .laser_detect(pin[4]), .ref_status(rs), .level_over(lo), .level_hot(lh),
        .audio_port_out(port_out), .port_chan_count(chan_cnt), .cpst_out_en(cpst_out_en),
        .embed_lamp(embed_lamp), .gain_lamp(gain_lamp), .level_meter_lamp(level_meter_lamp),
        .mon_vol_lamp(mon_vol_lamp), .audio_mode_lamp(amode_lamp), .in_hd_lamp(in_hd_lamp),
        .in_sd_lamp(in_sd_lamp), .ref_lamp(ref_lamp), .fmt_lamp(fmt_lamp),
        .laser_lamp(laser_lamp), .aspect_lamp(aspect_lamp), .bars_lamp(bars_lamp),
        .grat_lamp(grat_lamp), .vgain_lamp(vgain_lamp), .param_lamp_on(plamp_on),
        .param_lamp_idx(plamp_idx), .nv_we(nv_we), .nv_addr(nv_addr), .nv_data(nv_data));
    always #50 sys_clk = ~sys_clk;
    // count commits, keep the last one, and cut a hang short
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (nv_we === 1'b1) begin
            nv_cnt <= nv_cnt + 1;
            nv_last <= {nv_addr, nv_data};
        end
        if (cyc == 20000) begin
            num_errors++;
            test_done();
        end
    end
    task automatic test_done();
        if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    initial begin
        tick(10);
        reset <= 1'b0;
        tick(2);
        chk("gain_lamp", 32'h55, gain_lamp);
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, CTRL_OFS, m);
            tick(2);
            chk("port_dir", m == 0 ? 32'h0 : m == 1 ? 32'hc : 32'hf, port_out);
            chk("amode_lamp", 1 << m, amode_lamp);
            chk("chan_cnt", 32'haa, chan_cnt);
        end
        for (int f = 0; f < 5; f++) begin
            apb(1'b1, CTRL_OFS, (f << CTRL_FMT) | (f % 4 << CTRL_ASP) |
                (f % 2 << CTRL_BARS) | (f / 2 % 2 << CTRL_GRAT));
            tick(2);
            chk("fmt_lamp", 1 << f, fmt_lamp);
            chk("cpst_en", f == 4, cpst_out_en);
            chk("aspect", 1 << f % 4, aspect_lamp);
            chk("bars", f % 2 ? LAMP_GREEN : LAMP_OFF, bars_lamp);
            chk("grat", f / 2 % 2 ? LAMP_GREEN : LAMP_OFF, grat_lamp);
        end
        apb(1'b1, AGAIN_OFS, 32'h80807f81);
        lh <= 4'hc;
        lo <= 4'h8;
        tick(5);
        chk("gain_lamp", 32'h5a, gain_lamp);
        chk("level_lamp", 32'hba, level_meter_lamp);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, VGAIN_OFS, i ? 32'h8081 : 32'h7f80);
            tick(2);
            chk("vgain", i ? LAMP_RED : LAMP_GREEN, vgain_lamp);
            chk("monvol", i ? LAMP_GREEN : LAMP_RED, mon_vol_lamp);
        end
        for (int k = 0; k < 6; k++) begin
            pv = 5'(k * 7);
            pin <= pv;
            rs <= 3'(k);
            tick(5);
            apb(1'b0, STATUS_OFS, 32'h0);
            chk("embed", pv[0] && pv[1] ? LAMP_GREEN : LAMP_OFF, embed_lamp);
            chk("in_lamps", {pv[2], !pv[2], pv[3]}, {in_hd_lamp, in_sd_lamp, ref_lamp});
            chk("laser", pv[4] ? LAMP_GREEN : LAMP_OFF, laser_lamp);
            chk("status", {lh, lo, 3'(k), pv}, rd);
        end
        apb(1'b0, 12'h020, 32'h0);
        chk("slverr", 32'h1, er);
        fp.press(3'b100); // edit on, section 0
        fp.press(3'b011); // adjust on
        fp.press(3'b010); // param 0 up to 1
        apb(1'b0, EDIT_OFS, 32'h0);
        chk("edit", 32'hc1, rd);
        chk("nv_early", 32'h0, nv_cnt);
        lp = plamp_on;
        tick(4);
        chk("lamp_blink", 32'h1, lp ^ plamp_on);
        tick(CMT);
        chk("nv_word", 32'h001, nv_last);
        chk("lamp_steady", 32'h1, plamp_on);
        fp.press(3'b010);
        fp.press(3'b010); // second edit restarts the interval
        tick(CMT - 10);
        chk("nv_restart", 32'h1, nv_cnt);
        tick(14);
        chk("nv_word", 32'h003, nv_last);
        apb(1'b0, PARAM_OFS, 32'h0);
        chk("param0", 32'h3, rd);
        fp.press(3'b100); // next section
        fp.press(3'b010); // selection moves to 1
        apb(1'b0, EDIT_OFS, 32'h0);
        chk("edit", 32'h15, rd);
        fp.press(3'b011); // adjust on
        fp.press(3'b010); // param 5 up to 1
        fp.press(3'b001); // edit left pending across reset
        chk("lamp_idx", 32'h5, plamp_idx);
        reset <= 1'b1;
        tick(10);
        reset <= 1'b0;
        tick(CMT + 10);
        chk("nv_lost", 32'h2, nv_cnt);
        test_done();
    end
endmodule
